// *** src/pif_map.svh ***
// Purpose: Addresses, bit positions, reset values and fixed codes of the peripheral interrupt funnel.
// Assumes: Included by the package, the edge detector and the funnel top; definitions only.
// Notes:   Addresses are those seen on the peripheral port.
`ifndef PIF_MAP_SVH
`define PIF_MAP_SVH

// ==========================================================================
// Peripheral port map
`define PIF_ADDR_W          8
`define PIF_DATA_W          8
`define PIF_ADDR_FLAGS      8'h0E
`define PIF_ADDR_ENABLES    8'h0F
`define PIF_RDATA_UNMAPPED  8'h00
`define PIF_RST_FLAGS       8'h00
`define PIF_RST_ENABLES     8'h00
`define PIF_NO_CLEAR        8'h00

// ==========================================================================
// Bit positions shared by the flag and enable registers
`define PIF_BIT_POWER_FAIL  7
`define PIF_BIT_DIRECTION   6
`define PIF_BIT_CONVERTER   5
`define PIF_BIT_DETECT      4
`define PIF_BIT_CHG_OC      3
`define PIF_BIT_DIS_OC      2
`define PIF_BIT_CHG_WRAP    1
`define PIF_BIT_DIS_WRAP    0

// ==========================================================================
// Core side constants
`define PIF_VECTOR_W        12
`define PIF_VECTOR          12'h200
`define PIF_SMB_SRCS        4
`define PIF_EDGE_COUNT      3
`define PIF_EDGE_SUPPLY     0
`define PIF_EDGE_DIRECTION  1
`define PIF_EDGE_DETECT     2

`endif

// *** src/pif_pkg.sv ***
// Purpose: Types of the peripheral interrupt funnel.
// Assumes: pif_map.svh supplies all widths.
// Notes:   Each module keeps its whole state in one packed struct.
`include "pif_map.svh"

package pif_pkg;

    // ======================================================================
    // State of one edge detector.
    typedef struct packed {
        logic prev;
        logic primed;
        logic pulse;
    } pif_edge_state_t;

    // ======================================================================
    // State of the funnel top.
    typedef struct packed {
        logic [`PIF_DATA_W-1:0]   flags;
        logic [`PIF_DATA_W-1:0]   enables;
        logic [`PIF_DATA_W-1:0]   rdata;
        logic                     rvalid;
        logic                     ext_irq;
        logic                     smb_irq;
        logic                     per_irq;
        logic                     core_irq;
        logic [`PIF_VECTOR_W-1:0] vector;
        logic                     wake;
        logic                     osc_run;
    } pif_top_state_t;

endpackage

// *** src/pif_edge_if.sv ***
// Purpose: Carries one sampled level to an edge detector and its edge pulse back.
// Assumes: One clock shared by both ends.
// Notes:   The user end drives the level, the detector end the pulse.
`timescale 1ns/1ps

interface pif_edge_if;
    logic level;
    logic edge_pulse;

    modport detector (input level, output edge_pulse);
    modport user     (output level, input edge_pulse);
endinterface

// *** src/pif_edge.sv ***
// Purpose: Dual-edge detector producing a one-cycle pulse per change of level.
// Assumes: The level is synchronous to clk_in.
// Notes:   The first sample after reset only primes the detector, unless
//          REPORT_FIRST_HIGH asks that a high first sample count as a rise.
`timescale 1ns/1ps
`include "pif_map.svh"

module pif_edge #(
    parameter bit REPORT_FIRST_HIGH = 1'b0
) (
    input  wire logic     clk_in,
    input  wire logic     srst_in,
    pif_edge_if.detector  port
);

    pif_pkg::pif_edge_state_t st_r;
    pif_pkg::pif_edge_state_t st_nxt;

    // ======================================================================
    // Next state: compare with the last sample; without priming, a pin that
    // is already high at reset would raise a false edge.
    always_comb begin
        st_nxt        = st_r;
        st_nxt.prev   = port.level;
        st_nxt.primed = 1'b1;
        if (st_r.primed) begin
            st_nxt.pulse = port.level ^ st_r.prev;
        end else begin
            st_nxt.pulse = REPORT_FIRST_HIGH & port.level;
        end
    end

    // ======================================================================
    // State register.
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign port.edge_pulse = st_r.pulse;

endmodule

// *** src/pif_top.sv ***
// Purpose: Peripheral interrupt funnel: eight sticky event flags, their
//          enables, and the three equal-priority core interrupt inputs.
// Assumes: One 25 MHz clock; all inputs synchronous to it; srst_in is the
//          power-on reset; peripheral port strobes last one cycle.
// Notes:   Read data is registered and valid one cycle after the read strobe.
//
// Overview of operation
// - Every taken interrupt vectors to 0x0200.
// - Three core inputs share one equal priority.
// - First core input comes from pin seven.
// - SMBus events reach the core only via input two.
// - Eight sticky flags, one per peripheral source.
// - Flags set even when their enable is clear.
// - Reading flags never changes them.
// - Writing ones clears exactly those flags.
// - Third input asserted when enabled flag is set.
// - Reading enables returns them, unchanged.
// - Enables cleared by master clear and power-on.
// - Flag order: power-fail down to discharge wrap.
// - Enable bit sits at its flag's position.
// - Power-fail flag sets on supply crossing 3V.
// - Detect flag sets on either pin edge.
// - Any interrupt wakes core and restarts oscillator.
// - Direction flag sets on each current reversal.
`timescale 1ns/1ps
`include "pif_map.svh"

module pif_top (
    input  wire logic                      clk_in,
    input  wire logic                      srst_in,
    input  wire logic                      master_clear_n_in,
    input  wire logic [`PIF_ADDR_W-1:0]    pp_addr_in,
    input  wire logic                      pp_wr_in,
    input  wire logic                      pp_rd_in,
    input  wire logic [`PIF_DATA_W-1:0]    pp_wdata_in,
    input  wire logic                      gpio_pin_seven_in,
    input  wire logic [`PIF_SMB_SRCS-1:0]  smbus_src_in,
    input  wire logic                      supply_above_3v_in,
    input  wire logic                      current_charging_in,
    input  wire logic                      detect_pin_in,
    input  wire logic                      adc_event_in,
    input  wire logic                      charge_overcurrent_in,
    input  wire logic                      discharge_overcurrent_in,
    input  wire logic                      charge_count_wrap_in,
    input  wire logic                      discharge_count_wrap_in,
    input  wire logic                      core_sleep_in,
    input  wire logic                      sleep_osc_off_select_in,
    output logic      [`PIF_DATA_W-1:0]    pp_rdata_out,
    output logic                           pp_rvalid_out,
    output logic                           external_pin_irq_out,
    output logic                           smbus_irq_input_out,
    output logic                           peripheral_irq_input_out,
    output logic                           core_irq_out,
    output logic      [`PIF_VECTOR_W-1:0]  irq_vector_out,
    output logic                           wake_out,
    output logic                           osc_run_out
);

    pif_pkg::pif_top_state_t    st_r;
    pif_pkg::pif_top_state_t    st_nxt;
    logic [`PIF_DATA_W-1:0]     event_vec;
    logic [`PIF_DATA_W-1:0]     clear_vec;
    logic                       wr_flags;
    logic                       wr_enables;

    // ======================================================================
    // Edge detectors
    // Supply, current direction and detect pin are levels whose changes are
    // events. The supply detector counts a high first sample as a rise, so a
    // supply already good at release of power-on still raises its warning.
    pif_edge_if eif [`PIF_EDGE_COUNT] ();

    assign eif[`PIF_EDGE_SUPPLY].level    = supply_above_3v_in;
    assign eif[`PIF_EDGE_DIRECTION].level = current_charging_in;
    assign eif[`PIF_EDGE_DETECT].level    = detect_pin_in;

    genvar gi;
    generate
        for (gi = 0; gi < `PIF_EDGE_COUNT; gi++) begin : g_edge
            pif_edge #(
                .REPORT_FIRST_HIGH (gi == `PIF_EDGE_SUPPLY)
            ) u_edge (
                .clk_in  (clk_in),
                .srst_in (srst_in),
                .port    (eif[gi])
            );
        end
    endgenerate

    // ======================================================================
    // Event vector in flag-bit order.
    always_comb begin
        event_vec                       = '0;
        event_vec[`PIF_BIT_POWER_FAIL]  = eif[`PIF_EDGE_SUPPLY].edge_pulse;
        event_vec[`PIF_BIT_DIRECTION]   = eif[`PIF_EDGE_DIRECTION].edge_pulse;
        event_vec[`PIF_BIT_CONVERTER]   = adc_event_in;
        event_vec[`PIF_BIT_DETECT]      = eif[`PIF_EDGE_DETECT].edge_pulse;
        event_vec[`PIF_BIT_CHG_OC]      = charge_overcurrent_in;
        event_vec[`PIF_BIT_DIS_OC]      = discharge_overcurrent_in;
        event_vec[`PIF_BIT_CHG_WRAP]    = charge_count_wrap_in;
        event_vec[`PIF_BIT_DIS_WRAP]    = discharge_count_wrap_in;
    end

    // ======================================================================
    // Peripheral port decode.
    assign wr_flags   = pp_wr_in && (pp_addr_in == `PIF_ADDR_FLAGS);
    assign wr_enables = pp_wr_in && (pp_addr_in == `PIF_ADDR_ENABLES);
    assign clear_vec  = wr_flags ? pp_wdata_in : `PIF_NO_CLEAR;

    // ======================================================================
    // Next state of the funnel.
    // The core outputs are built from the next flag and enable values so
    // that they line up with the registers they are derived from.
    always_comb begin
        st_nxt = st_r;

        // Ones clear, zeros keep; a same-cycle event is ORed in last, so it
        // survives the clear. Enables play no part here.
        st_nxt.flags = (st_r.flags & ~clear_vec) | event_vec;

        // Master clear holds the enables at zero while asserted.
        if (!master_clear_n_in) begin
            st_nxt.enables = `PIF_RST_ENABLES;
        end else if (wr_enables) begin
            st_nxt.enables = pp_wdata_in;
        end

        // Reads only copy state; they have no side effect on any flag.
        st_nxt.rvalid = pp_rd_in;
        st_nxt.rdata  = `PIF_RDATA_UNMAPPED;
        if (pp_rd_in) begin
            unique case (pp_addr_in)
                `PIF_ADDR_FLAGS:   st_nxt.rdata = st_r.flags;
                `PIF_ADDR_ENABLES: st_nxt.rdata = st_r.enables;
                default:           st_nxt.rdata = `PIF_RDATA_UNMAPPED;
            endcase
        end

        // Bitwise gate: each enable sits over the flag of the same position.
        st_nxt.per_irq  = |(st_nxt.flags & st_nxt.enables);
        st_nxt.ext_irq  = gpio_pin_seven_in;
        st_nxt.smb_irq  = |smbus_src_in;

        // Plain OR: no input is preferred, so no priority encoder exists.
        st_nxt.core_irq = st_nxt.ext_irq | st_nxt.smb_irq | st_nxt.per_irq;
        st_nxt.vector   = `PIF_VECTOR;

        // Wake overrides the oscillator-off choice made for sleep.
        st_nxt.wake     = core_sleep_in & st_nxt.core_irq;
        st_nxt.osc_run  = ~(core_sleep_in & sleep_osc_off_select_in) | st_nxt.core_irq;
    end

    // ======================================================================
    // State register; power-on clears flags and enables alike.
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            st_r          <= '0;
            st_r.flags    <= `PIF_RST_FLAGS;
            st_r.enables  <= `PIF_RST_ENABLES;
            st_r.vector   <= `PIF_VECTOR;
            st_r.osc_run  <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ======================================================================
    // Outputs, each straight from the state register.
    assign pp_rdata_out             = st_r.rdata;
    assign pp_rvalid_out            = st_r.rvalid;
    assign external_pin_irq_out     = st_r.ext_irq;
    assign smbus_irq_input_out      = st_r.smb_irq;
    assign peripheral_irq_input_out = st_r.per_irq;
    assign core_irq_out             = st_r.core_irq;
    assign irq_vector_out           = st_r.vector;
    assign wake_out                 = st_r.wake;
    assign osc_run_out              = st_r.osc_run;

    // ======================================================================
    // Checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);

    // The vector never moves, whatever input fires.
    vector_fixed_a: assert property (
        core_irq_out |-> irq_vector_out == `PIF_VECTOR
    ) else $error("Interrupt vector is not the fixed address.");

    // The combined request is the plain OR of the three inputs.
    core_or_a: assert property (
        core_irq_out == (external_pin_irq_out | smbus_irq_input_out | peripheral_irq_input_out)
    ) else $error("Core request is not the OR of its three inputs.");

    // Pin seven reaches the first input one cycle later.
    pin_seven_a: assert property (
        ##1 external_pin_irq_out == $past(gpio_pin_seven_in)
    ) else $error("First core input does not follow pin seven.");

    // SMBus sources appear on input two and never in the flags.
    smbus_route_a: assert property (
        ##1 smbus_irq_input_out == $past(|smbus_src_in)
    ) else $error("SMBus sources not routed to the second input.");

    // Without a clear, a set flag stays set however often it is read.
    flag_sticky_a: assert property (
        ##1 ((($past(st_r.flags) & ~$past(clear_vec)) & ~st_r.flags) == `PIF_NO_CLEAR)
    ) else $error("A flag dropped without a clear.");

    // Every event sets its flag, enabled or not, even under a clear.
    event_sets_a: assert property (
        ##1 (($past(event_vec) & ~st_r.flags) == `PIF_NO_CLEAR)
    ) else $error("An event did not set its flag.");

    // A write with no events clears exactly the written ones.
    clear_exact_a: assert property (
        (wr_flags && event_vec == `PIF_NO_CLEAR) |=> st_r.flags == ($past(st_r.flags) & ~$past(pp_wdata_in))
    ) else $error("Flag clear did not match the written ones.");

    // The third input is the gated OR of flags and enables.
    gated_irq_a: assert property (
        peripheral_irq_input_out == |(st_r.flags & st_r.enables)
    ) else $error("Third input disagrees with flags and enables.");

    // Master clear leaves every enable at zero on the next edge.
    master_clear_a: assert property (
        !master_clear_n_in |=> st_r.enables == `PIF_RST_ENABLES
    ) else $error("Enables not cleared by master clear.");

    // An enable read returns the stored value and keeps it.
    enable_read_a: assert property (
        (pp_rd_in && pp_addr_in == `PIF_ADDR_ENABLES && !pp_wr_in && master_clear_n_in)
            |=> pp_rvalid_out && pp_rdata_out == $past(st_r.enables) && st_r.enables == $past(st_r.enables)
    ) else $error("Enable read wrong or disturbed the register.");

    // A wake comes only with a request, and the oscillator then runs.
    wake_osc_a: assert property (
        wake_out |-> core_irq_out && osc_run_out
    ) else $error("Wake without request or with oscillator stopped.");

    // ======================================================================
    // Checks on the register port, the edge sources and the wake path

    // A read of the flags returns their value from before the edge.
    flag_read_a: assert property (
        (pp_rd_in && pp_addr_in == `PIF_ADDR_FLAGS) |=> pp_rvalid_out && pp_rdata_out == $past(st_r.flags)
    ) else $error("Flag read did not return the stored flags.");

    // A read alone, with no event and no write, leaves every flag as it was.
    flag_read_keep_a: assert property (
        (pp_rd_in && !pp_wr_in && event_vec == `PIF_NO_CLEAR) |=> st_r.flags == $past(st_r.flags)
    ) else $error("A read changed the flags.");

    // Read valid follows the read strobe by exactly one cycle.
    rvalid_pulse_a: assert property (
        ##1 pp_rvalid_out == $past(pp_rd_in)
    ) else $error("Read valid does not follow the read strobe.");

    // Between writes and master clears the enables hold their value.
    enable_hold_a: assert property (
        (!wr_enables && master_clear_n_in) |=> st_r.enables == $past(st_r.enables)
    ) else $error("Enables moved without a write.");

    // A write outside master clear stores every enable bit in place.
    enable_write_a: assert property (
        (wr_enables && master_clear_n_in) |=> st_r.enables == $past(pp_wdata_in)
    ) else $error("Enable write not stored bit for bit.");

    // With every enable clear, nothing reaches the third input.
    enable_gate_a: assert property (
        (st_r.enables == `PIF_RST_ENABLES) |-> !peripheral_irq_input_out
    ) else $error("Third input raised with all enables clear.");

    // A flag rises only from its own peripheral event, never from SMBus.
    flag_source_a: assert property (
        ##1 ((st_r.flags & ~$past(st_r.flags) & ~$past(event_vec)) == `PIF_NO_CLEAR)
    ) else $error("A flag rose without an event.");

    // An enabled event raises the third input and the core request.
    event_irq_a: assert property (
        (|(event_vec & st_r.enables) && master_clear_n_in && !wr_enables)
            |=> peripheral_irq_input_out && core_irq_out
    ) else $error("Enabled event did not raise the request.");

    // A supply crossing sets the warning on the edge after it is sampled, checked one edge later.
    supply_edge_a: assert property (
        ($changed(supply_above_3v_in) && !$past(srst_in)) |=> ##1 st_r.flags[`PIF_BIT_POWER_FAIL]
    ) else $error("Supply crossing did not set the warning flag.");

    // Every reversal of current flow sets the direction flag.
    direction_edge_a: assert property (
        ($changed(current_charging_in) && !$past(srst_in)) |=> ##1 st_r.flags[`PIF_BIT_DIRECTION]
    ) else $error("Current reversal did not set the direction flag.");

    // Either edge of the detect pin sets the detect flag.
    detect_edge_a: assert property (
        ($changed(detect_pin_in) && !$past(srst_in)) |=> ##1 st_r.flags[`PIF_BIT_DETECT]
    ) else $error("Detect pin edge did not set its flag.");

    // A request during sleep wakes the core with its oscillator running.
    irq_wake_a: assert property (
        (core_sleep_in && master_clear_n_in && !wr_enables
            && (gpio_pin_seven_in || |smbus_src_in || |(event_vec & st_r.enables)))
            |=> wake_out && osc_run_out
    ) else $error("Sleeping core not woken by a request.");

    // Sleep with the oscillator-off choice stops it unless a request stands.
    osc_stop_a: assert property (
        (core_sleep_in && sleep_osc_off_select_in) |=> osc_run_out == core_irq_out
    ) else $error("Oscillator state wrong during sleep.");

endmodule

// *** test/pif_core_model.sv ***
// Purpose: Core-side model of the peripheral port that issues register writes and reads.
// Assumes: Strobes last one cycle; read data arrives within three cycles of the strobe.
// Notes:   Between strobes the address and data show the inverse of their last value.
`timescale 1ns/1ps
`include "pif_map.svh"

module pif_core_model (
    input  wire logic                   clk_in,
    input  wire logic [`PIF_DATA_W-1:0] pp_rdata_in,
    input  wire logic                   pp_rvalid_in,
    output logic      [`PIF_ADDR_W-1:0] pp_addr_out,
    output logic                        pp_wr_out,
    output logic                        pp_rd_out,
    output logic      [`PIF_DATA_W-1:0] pp_wdata_out
);
    // ======================================================================
    // Idle port state at time zero.
    initial begin
        pp_addr_out = 8'h00;
        pp_wr_out = 1'b0;
        pp_rd_out = 1'b0;
        pp_wdata_out = 8'h00;
    end

    // Released address and data lines are inverted and both strobes drop low, so a stale value is never taken for a fresh one.
    task automatic release_bus();
        pp_wr_out = 1'b0;
        pp_rd_out = 1'b0;
        pp_addr_out = ~pp_addr_out;
        pp_wdata_out = ~pp_wdata_out;
    endtask

    // One-cycle write strobe to any register; at the flags address the ones written clear those flags.
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clk_in);
        #1;
        pp_addr_out = addr;
        pp_wdata_out = data;
        pp_wr_out = 1'b1;
        @(posedge clk_in);
        #1;
        release_bus();
    endtask

    // Read with a bounded wait on the valid pulse.
    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data, output logic ok);
        int i;
        ok = 1'b0;
        data = 8'h00;
        @(posedge clk_in);
        #1;
        pp_addr_out = addr;
        pp_rd_out = 1'b1;
        @(posedge clk_in);
        #1;
        release_bus();
        for (i = 0; i < 3 && ok == 1'b0; i++) begin
            if (pp_rvalid_in === 1'b1) begin
                ok = 1'b1;
                data = pp_rdata_in;
            end else begin
                @(posedge clk_in);
                #1;
            end
        end
    endtask
endmodule

// *** test/tb_peripheral_interrupt_funnel.sv ***
// Purpose: Self-checking bench of the peripheral interrupt funnel.
// Assumes: 25 MHz clock; inputs change 1 ns after the rising edge.
// Notes:   Each scenario is a task that drives and judges on its own.
`timescale 1ns/1ps
`include "pif_map.svh"

`define CHK(what, exp, got) begin checks++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got); end end

module tb_peripheral_interrupt_funnel;
    logic       clk_in, srst_in, master_clear_n_n, pin7, sleep, osc_off, pp_wr, pp_rd, rvalid;
    logic       ext_irq, smb_irq, per_irq, core_irq, wake, osc_run, ok;
    logic [7:0] src, addr, wdata, rdata, got;
    logic [3:0] smb;
    logic [11:0] vec;
    int         n_mismatch, checks, cycles;

    // ======================================================================
    // Clock, stimulus defaults and instances.
    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end
    initial begin
        {srst_in, master_clear_n_n, pin7, sleep, osc_off, src, smb} = {1'b1, 1'b1, 3'b000, 8'h00, 4'h0};
        n_mismatch = 0;
        checks = 0;
        cycles = 0;
    end

    pif_core_model core (.clk_in(clk_in), .pp_rdata_in(rdata), .pp_rvalid_in(rvalid), .pp_addr_out(addr),
        .pp_wr_out(pp_wr), .pp_rd_out(pp_rd), .pp_wdata_out(wdata));

    pif_top dut (.clk_in(clk_in), .srst_in(srst_in), .master_clear_n_in(master_clear_n_n), .pp_addr_in(addr),
        .pp_wr_in(pp_wr), .pp_rd_in(pp_rd), .pp_wdata_in(wdata), .gpio_pin_seven_in(pin7),
        .smbus_src_in(smb), .supply_above_3v_in(src[`PIF_BIT_POWER_FAIL]),
        .current_charging_in(src[`PIF_BIT_DIRECTION]), .detect_pin_in(src[`PIF_BIT_DETECT]),
        .adc_event_in(src[`PIF_BIT_CONVERTER]), .charge_overcurrent_in(src[`PIF_BIT_CHG_OC]),
        .discharge_overcurrent_in(src[`PIF_BIT_DIS_OC]), .charge_count_wrap_in(src[`PIF_BIT_CHG_WRAP]),
        .discharge_count_wrap_in(src[`PIF_BIT_DIS_WRAP]), .core_sleep_in(sleep),
        .sleep_osc_off_select_in(osc_off), .pp_rdata_out(rdata), .pp_rvalid_out(rvalid),
        .external_pin_irq_out(ext_irq), .smbus_irq_input_out(smb_irq), .peripheral_irq_input_out(per_irq),
        .core_irq_out(core_irq), .irq_vector_out(vec), .wake_out(wake), .osc_run_out(osc_run));

    // A hang counts as a mismatch; the ceiling is far above the roughly 140 cycles needed.
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("mismatches %0d checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        core.read_reg(a, got, ok);
        `CHK("read valid", 1'b1, ok)
        `CHK("read data", exp, got)
    endtask

    // Edge sources toggle their level; the others pulse high for one cycle.
    task automatic fire(input int b);
        if (b == `PIF_BIT_POWER_FAIL || b == `PIF_BIT_DIRECTION || b == `PIF_BIT_DETECT) src[b] = ~src[b];
        else src[b] = 1'b1;
        wait_cyc(1);
        src[b] = src[b] & (b == `PIF_BIT_POWER_FAIL || b == `PIF_BIT_DIRECTION || b == `PIF_BIT_DETECT);
        wait_cyc(3);
    endtask

    // ======================================================================
    // Scenarios.
    task automatic t_reset();
        rd_chk(`PIF_ADDR_FLAGS, `PIF_RST_FLAGS);
        rd_chk(`PIF_ADDR_ENABLES, `PIF_RST_ENABLES);
        `CHK("vector", `PIF_VECTOR, vec)
        rd_chk(8'h10, `PIF_RDATA_UNMAPPED);
    endtask

    task automatic t_masked();
        logic [7:0] exp;
        exp = 8'h00;
        for (int b = 0; b < 8; b++) begin
            fire(b);
            exp[b] = 1'b1;
            rd_chk(`PIF_ADDR_FLAGS, exp);
            `CHK("masked irq", 1'b0, per_irq)
        end
        rd_chk(`PIF_ADDR_FLAGS, 8'hFF);
        core.write_reg(`PIF_ADDR_FLAGS, 8'h0F);
        rd_chk(`PIF_ADDR_FLAGS, 8'hF0);
        core.write_reg(`PIF_ADDR_FLAGS, 8'hF0);
        fire(`PIF_BIT_POWER_FAIL);
        fire(`PIF_BIT_DETECT);
        rd_chk(`PIF_ADDR_FLAGS, 8'h90);
        core.write_reg(`PIF_ADDR_FLAGS, 8'hFF);
    endtask

    task automatic t_irq();
        core.write_reg(`PIF_ADDR_ENABLES, 8'h02);
        rd_chk(`PIF_ADDR_ENABLES, 8'h02);
        rd_chk(`PIF_ADDR_ENABLES, 8'h02);
        {sleep, osc_off} = 2'b11;
        fire(`PIF_BIT_DIS_WRAP);
        `CHK("bit0 masked", 1'b0, per_irq)
        `CHK("osc off", 1'b0, osc_run)
        fire(`PIF_BIT_CHG_WRAP);
        `CHK("per irq", 1'b1, per_irq)
        `CHK("core irq", 1'b1, core_irq)
        `CHK("wake", 1'b1, wake)
        `CHK("osc run", 1'b1, osc_run)
        core.write_reg(`PIF_ADDR_FLAGS, 8'h03);
        wait_cyc(1);
        `CHK("cleared irq", 1'b0, core_irq)
        {sleep, osc_off} = 2'b00;
        // Clear and a fresh event on the same bit in the same cycle.
        fork
            core.write_reg(`PIF_ADDR_FLAGS, 8'h02);
            begin
                wait_cyc(1);
                src[`PIF_BIT_CHG_WRAP] = 1'b1;
                wait_cyc(1);
                src[`PIF_BIT_CHG_WRAP] = 1'b0;
            end
        join
        rd_chk(`PIF_ADDR_FLAGS, 8'h02);
        master_clear_n_n = 1'b0;
        wait_cyc(2);
        rd_chk(`PIF_ADDR_ENABLES, 8'h00);
        rd_chk(`PIF_ADDR_FLAGS, 8'h02);
        master_clear_n_n = 1'b1;
        core.write_reg(`PIF_ADDR_FLAGS, 8'hFF);
    endtask

    task automatic t_core_inputs();
        pin7 = 1'b1;
        wait_cyc(2);
        `CHK("pin irq", 1'b1, ext_irq)
        `CHK("core irq pin", 1'b1, core_irq)
        `CHK("no wake awake", 1'b0, wake)
        `CHK("osc awake", 1'b1, osc_run)
        pin7 = 1'b0;
        smb = 4'h4;
        wait_cyc(2);
        `CHK("pin idle", 1'b0, ext_irq)
        `CHK("smbus irq", 1'b1, smb_irq)
        `CHK("core irq smbus", 1'b1, core_irq)
        `CHK("smbus not funnelled", 1'b0, per_irq)
        rd_chk(`PIF_ADDR_FLAGS, 8'h00);
        smb = 4'h0;
        wait_cyc(2);
        `CHK("all idle", 1'b0, core_irq)
    endtask

    // Power-on in mid-run: flags and enables fall to zero, while a supply
    // already good at release still raises its warning.
    task automatic t_por();
        core.write_reg(`PIF_ADDR_ENABLES, 8'hFF);
        fire(`PIF_BIT_CHG_OC);
        `CHK("pre por irq", 1'b1, per_irq)
        src[`PIF_BIT_POWER_FAIL] = 1'b1;
        srst_in = 1'b1;
        wait_cyc(3);
        `CHK("por irq", 1'b0, core_irq)
        `CHK("por vector", `PIF_VECTOR, vec)
        srst_in = 1'b0;
        wait_cyc(3);
        rd_chk(`PIF_ADDR_FLAGS, 8'h80);
        rd_chk(`PIF_ADDR_ENABLES, `PIF_RST_ENABLES);
        `CHK("por per irq", 1'b0, per_irq)
    endtask

    // ======================================================================
    // Main sequence.
    initial begin
        wait_cyc(10);
        srst_in = 1'b0;
        wait_cyc(2);
        t_reset();
        t_masked();
        t_irq();
        t_core_inputs();
        t_por();
        end_sim();
    end
endmodule
